// [bmr_regfile.sv]
// banked mode register file with status words, exception entry and return
// ---------------------------------------------------------------
// Summary of operation
// - instructions pass fetch, decode, execute stages in that order
// - instruction words are 32 bits wide state, 16 bits compact state
// - byte, halfword, word data; words four-byte, halfwords two-byte aligned
// - seven modes: user, fast irq, irq, supervisor, abort, system, undefined
// - mode changes by software write or exception, entering privileged mode
// - 37 registers: 31 general 32-bit plus 6 status words
// - 16 registers visible, chosen by mode
// - register 15 is the program counter, usable for relative addressing
// - registers 0 to 7 share storage in every mode
// - each exception mode has private stack pointer and return link
// - fast interrupt mode also has private registers 8 to 12
// - system mode uses user registers yet stays privileged
// - exception entry writes return address into that mode's link
// - subroutine call leaves return address in current mode's link
// - status word: four flags, two disables, state bit, five-bit mode
// - each exception mode saves the prior status word on entry
// - five exception types, each with its own privileged mode
// - several exception requests in one cycle are taken one per boundary, by priority
// - return copies saved status to current and link to counter
// - wide instructions execute only when bits 31:28 condition passes
// ---------------------------------------------------------------
module bmr_regfile
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fast_pin,
  input wire logic irq_pin,
  input wire logic abort_req,
  input wire logic undef_req,
  input wire logic trap_req,
  input wire logic exc_allow,
  input wire logic ret_dp_req,
  input wire logic ret_lmr_req,
  input wire logic call_req,
  input wire logic step,
  input wire logic [31:0] fetch_word,
  input wire logic [3:0] rd_a_idx,
  input wire logic [3:0] rd_b_idx,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [31:0] wr_data,
  input wire logic flag_we,
  input wire logic [3:0] flag_nzcv,
  input wire logic dacc_valid,
  input wire logic [31:0] dacc_addr,
  input wire bmr_pkg::bmr_size_type dacc_size,
  output logic [31:0] rd_a_data,
  output logic [31:0] rd_b_data,
  output logic [31:0] program_counter,
  output logic [31:0] current_status_word,
  output logic [31:0] exe_word,
  output logic exe_fire,
  output logic dacc_misaligned,
  output logic privileged
);
  import bmr_pkg::*;

  // ---------------------------------------------------------------
  // shared decode
  // ---------------------------------------------------------------
  // physical slot of a visible register 0..14; 15 lives in pc_q
  function automatic logic [4:0] bmr_phys(input logic [4:0] m, input logic [3:0] r);
    logic [4:0] base;
    base = 5'd18;
    unique case (m)
      `BMR_MODE_SVC: base = 5'd20;
      `BMR_MODE_ABT: base = 5'd22;
      `BMR_MODE_UND: base = 5'd24;
      `BMR_MODE_IRQ: base = 5'd26;
      `BMR_MODE_FAST: base = 5'd28;
      default: base = 5'd18; // user and system share the user bank
    endcase
    if (r < 4'd8)
      return {1'b0, r};
    else if (r < 4'd13)
      return (m == `BMR_MODE_FAST) ? 5'(r) + 5'd5 : {1'b0, r};
    else
      return base + 5'(r - 4'd13);
  endfunction : bmr_phys

  // saved word slot of a mode; none for user and system
  function automatic logic [2:0] bmr_saved_idx(input logic [4:0] m);
    unique case (m)
      `BMR_MODE_SVC: return 3'h0;
      `BMR_MODE_ABT: return 3'h1;
      `BMR_MODE_UND: return 3'h2;
      `BMR_MODE_IRQ: return 3'h3;
      `BMR_MODE_FAST: return 3'h4;
      default: return `BMR_NO_SAVED;
    endcase
  endfunction : bmr_saved_idx

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  // 30 banked and shared slots plus pc_q make the 31 general registers
  logic [31:0] gpr_q [0:29];
  logic [31:0] saved_q [0:4];
  logic [31:0] pc_q, pc_d;
  logic [31:0] stat_q, stat_d;
  logic [4:0] pend_q, pend_d;
  logic [3:0] sel_q;
  logic [1:0] fast_s_q, irq_s_q;
  logic busy_q;
  logic [31:0] prdata_q, rd_a_q, rd_b_q, dec_q, exe_q;
  logic dacc_mis_q;
  bmr_pipe_type pipe_q, pipe_d;

  // ---------------------------------------------------------------
  // status decode
  // ---------------------------------------------------------------
  logic [4:0] mode_w;
  logic compact_w, priv_w;
  logic [2:0] sidx_w;
  logic [31:0] step_w, link_w;
  assign mode_w = stat_q[`BMR_MODE_MSB:0];
  assign compact_w = stat_q[`BMR_STATE_BIT];
  assign priv_w = mode_w != `BMR_MODE_USR;
  assign sidx_w = bmr_saved_idx(mode_w);
  assign step_w = compact_w ? `BMR_STEP_COMPACT : `BMR_STEP_WIDE;
  // fetch runs two steps ahead, so the next instruction is one step back
  assign link_w = pc_q - step_w;

  function automatic logic [31:0] bmr_read(input logic [3:0] r);
    return (r == 4'hf) ? pc_q : gpr_q[bmr_phys(mode_w, r)];
  endfunction : bmr_read

  // ---------------------------------------------------------------
  // exception arbitration
  // ---------------------------------------------------------------
  // interrupt pins are levels from outside; abort, undef, trap are pulses
  logic [4:0] req_w, avail_w, grant_w, apb_raise_w;
  logic exc_take_w, ret_w, call_w, wr_w, branch_w, flush_w;
  assign req_w[`BMR_EXC_FAST] = fast_s_q[1];
  assign req_w[`BMR_EXC_IRQ] = irq_s_q[1];
  assign req_w[`BMR_EXC_ABT] = pend_q[`BMR_EXC_ABT] | abort_req;
  assign req_w[`BMR_EXC_UND] = pend_q[`BMR_EXC_UND] | undef_req;
  assign req_w[`BMR_EXC_TRAP] = pend_q[`BMR_EXC_TRAP] | trap_req;
  assign avail_w = req_w & {3'b111, ~stat_q[`BMR_IRQ_OFF_BIT], ~stat_q[`BMR_FAST_OFF_BIT]};
  assign grant_w[`BMR_EXC_ABT] = exc_allow & avail_w[2];
  assign grant_w[`BMR_EXC_FAST] = exc_allow & avail_w[0] & ~avail_w[2];
  assign grant_w[`BMR_EXC_IRQ] = exc_allow & avail_w[1] & ~avail_w[2] & ~avail_w[0];
  assign grant_w[`BMR_EXC_UND] = exc_allow & avail_w[3] & ~(|avail_w[2:0]);
  assign grant_w[`BMR_EXC_TRAP] = exc_allow & avail_w[4] & ~(|avail_w[3:0]);
  assign exc_take_w = |grant_w;

  logic [4:0] new_mode_w;
  logic [31:0] vec_w;
  assign new_mode_w = grant_w[2] ? `BMR_MODE_ABT : grant_w[0] ? `BMR_MODE_FAST
    : grant_w[1] ? `BMR_MODE_IRQ : grant_w[3] ? `BMR_MODE_UND : `BMR_MODE_SVC;
  assign vec_w = grant_w[2] ? `BMR_VEC_ABT : grant_w[0] ? `BMR_VEC_FAST
    : grant_w[1] ? `BMR_VEC_IRQ : grant_w[3] ? `BMR_VEC_UND : `BMR_VEC_TRAP;

  // a return from a mode without a saved word is ignored
  assign ret_w = (ret_dp_req | ret_lmr_req) & (sidx_w != `BMR_NO_SAVED) & ~exc_take_w;
  assign call_w = call_req & ~exc_take_w & ~ret_w;
  assign wr_w = wr_en & ~exc_take_w & ~ret_w;
  assign branch_w = wr_w & (wr_idx == 4'hf);
  assign flush_w = exc_take_w | ret_w | branch_w;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic core_busy_w, acc_w, apb_wr_w, hit_w;
  logic hit_st_w, hit_sv_w, hit_sel_w, hit_dat_w, hit_pend_w, hit_info_w;
  logic [31:0] rmux_w, info_w;
  assign core_busy_w = exc_take_w | ret_w | call_w | wr_w | flag_we;
  // reads hold one more cycle after core activity so prdata_q is current
  assign pready = ~core_busy_w & ~busy_q;
  assign acc_w = psel & penable & pready;
  assign apb_wr_w = acc_w & pwrite;
  assign hit_st_w = paddr == `BMR_OFF_STATUS;
  assign hit_sv_w = paddr == `BMR_OFF_SAVED;
  assign hit_sel_w = paddr == `BMR_OFF_REG_SEL;
  assign hit_dat_w = paddr == `BMR_OFF_REG_DATA;
  assign hit_pend_w = paddr == `BMR_OFF_EXC_PEND;
  assign hit_info_w = paddr == `BMR_OFF_INFO;
  assign hit_w = hit_st_w | hit_sv_w | hit_sel_w | hit_dat_w | hit_pend_w | hit_info_w;
  assign pslverr = psel & penable & ~hit_w;
  assign prdata = prdata_q;
  assign info_w = {24'h0, pipe_q, 5'h0, compact_w};
  assign rmux_w = hit_st_w ? stat_q
    : hit_sv_w ? ((sidx_w == `BMR_NO_SAVED) ? 32'h0 : saved_q[sidx_w])
    : hit_sel_w ? {28'h0, sel_q}
    : hit_dat_w ? bmr_read(sel_q)
    : hit_pend_w ? {27'h0, req_w}
    : hit_info_w ? info_w : 32'h0;
  // software may raise undefined or trap exceptions
  assign apb_raise_w = (apb_wr_w & hit_pend_w) ? {pwdata[4:3], 3'h0} : 5'h0;
  // set wins over the clear of a taken request
  assign pend_d = {trap_req, undef_req, abort_req, 2'b00} | apb_raise_w
    | ({pend_q[4:2], 2'b00} & ~grant_w);

  // ---------------------------------------------------------------
  // register write port
  // ---------------------------------------------------------------
  logic gpr_we_w;
  logic [4:0] gpr_widx_w;
  logic [31:0] gpr_wdata_w;
  assign gpr_we_w = exc_take_w | call_w | (wr_w & ~branch_w)
    | (apb_wr_w & hit_dat_w & (sel_q != 4'hf));
  assign gpr_widx_w = exc_take_w ? bmr_phys(new_mode_w, 4'he)
    : call_w ? bmr_phys(mode_w, 4'he)
    : wr_w ? bmr_phys(mode_w, wr_idx) : bmr_phys(mode_w, sel_q);
  assign gpr_wdata_w = (exc_take_w | call_w) ? link_w : wr_w ? wr_data : pwdata;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int i = 0; i < 30; i++)
        gpr_q[i] <= 32'h0;
    else if (gpr_we_w)
      gpr_q[gpr_widx_w] <= gpr_wdata_w;
  end

  // ---------------------------------------------------------------
  // status words and program counter
  // ---------------------------------------------------------------
  logic [31:0] apb_st_w;
  // user mode software may only touch the flags
  assign apb_st_w = priv_w ? pwdata : {pwdata[31:28], stat_q[27:0]};

  always_comb
  begin
    stat_d = stat_q;
    if (exc_take_w)
      stat_d = {stat_q[31:8], 1'b1, stat_q[6] | grant_w[0], 1'b0, new_mode_w};
    else if (ret_w)
      stat_d = saved_q[sidx_w];
    else if (flag_we)
      stat_d = {flag_nzcv, stat_q[27:0]};
    else if (apb_wr_w & hit_st_w)
      stat_d = apb_st_w;
  end

  always_comb
  begin
    pc_d = pc_q;
    if (exc_take_w)
      pc_d = vec_w;
    else if (ret_w)
      pc_d = gpr_q[bmr_phys(mode_w, 4'he)];
    else if (branch_w)
      pc_d = wr_data & ~(step_w - 32'h1);
    else if (apb_wr_w & hit_dat_w & (sel_q == 4'hf))
      pc_d = pwdata & ~(step_w - 32'h1);
    else if (step)
      pc_d = pc_q + step_w;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_q <= `BMR_STATUS_RST;
      pc_q <= `BMR_PC_RST;
    end
    else
    begin
      stat_q <= stat_d;
      pc_q <= pc_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int i = 0; i < 5; i++)
        saved_q[i] <= 32'h0;
    else if (exc_take_w)
      saved_q[bmr_saved_idx(new_mode_w)] <= stat_q;
    else if (apb_wr_w & hit_sv_w & (sidx_w != `BMR_NO_SAVED))
      saved_q[sidx_w] <= pwdata;
  end

  // ---------------------------------------------------------------
  // pipeline
  // ---------------------------------------------------------------
  logic [31:0] fetch_ext_w;
  logic pass_w;
  assign fetch_ext_w = compact_w ? {16'h0, fetch_word[15:0]} : fetch_word;

  always_comb
  begin
    pipe_d = pipe_q;
    if (flush_w)
      pipe_d = BMR_PIPE_EMPTY;
    else if (step)
    begin
      unique case (pipe_q)
        BMR_PIPE_EMPTY: pipe_d = BMR_PIPE_HALF;
        BMR_PIPE_HALF: pipe_d = BMR_PIPE_FULL;
        BMR_PIPE_FULL: pipe_d = BMR_PIPE_FULL;
        default: pipe_d = BMR_PIPE_EMPTY; // code 2'b10 is illegal
      endcase
    end
  end

  bmr_cond_eval u_cond
  (
    .cond(exe_q[31:28]),
    .nzcv(stat_q[`BMR_FLAG_MSB:`BMR_FLAG_LSB]),
    .pass(pass_w)
  );

  // compact words carry no condition field
  assign exe_fire = (pipe_q == BMR_PIPE_FULL) & (compact_w | pass_w);
  assign exe_word = exe_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pipe_q <= BMR_PIPE_EMPTY;
      dec_q <= 32'h0;
      exe_q <= 32'h0;
    end
    else
    begin
      pipe_q <= pipe_d;
      if (step & ~flush_w)
      begin
        dec_q <= fetch_ext_w;
        exe_q <= dec_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // misalignment flag
  // ---------------------------------------------------------------
  logic mis_w;
  assign mis_w = dacc_valid & (((dacc_size == BMR_SZ_WORD) & (|dacc_addr[1:0]))
    | ((dacc_size == BMR_SZ_HALF) & dacc_addr[0]));

  // ---------------------------------------------------------------
  // sync, pending, read ports, apb regs
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fast_s_q <= 2'b00;
      irq_s_q <= 2'b00;
      pend_q <= 5'h0;
      sel_q <= 4'h0;
      busy_q <= 1'b0;
      prdata_q <= 32'h0;
      rd_a_q <= 32'h0;
      rd_b_q <= 32'h0;
      dacc_mis_q <= 1'b0;
    end
    else
    begin
      fast_s_q <= {fast_s_q[0], fast_pin};
      irq_s_q <= {irq_s_q[0], irq_pin};
      pend_q <= pend_d;
      if (apb_wr_w & hit_sel_w)
        sel_q <= pwdata[3:0];
      busy_q <= core_busy_w;
      if (psel & ~acc_w)
        prdata_q <= rmux_w;
      rd_a_q <= bmr_read(rd_a_idx);
      rd_b_q <= bmr_read(rd_b_idx);
      dacc_mis_q <= mis_w;
    end
  end

  assign rd_a_data = rd_a_q;
  assign rd_b_data = rd_b_q;
  assign program_counter = pc_q;
  assign current_status_word = stat_q;
  assign dacc_misaligned = dacc_mis_q;
  assign privileged = priv_w;
endmodule : bmr_regfile

// [bmr_defs.svh]
// constants for the banked mode register file: offsets, bit fields, codes
`ifndef BMR_DEFS_SVH
`define BMR_DEFS_SVH

// ---------------------------------------------------------------
// apb register offsets
// ---------------------------------------------------------------
`define BMR_OFF_STATUS 8'h00
`define BMR_OFF_SAVED 8'h04
`define BMR_OFF_REG_SEL 8'h08
`define BMR_OFF_REG_DATA 8'h0c
`define BMR_OFF_EXC_PEND 8'h10
`define BMR_OFF_INFO 8'h14

// ---------------------------------------------------------------
// status word fields
// ---------------------------------------------------------------
`define BMR_FLAG_MSB 31
`define BMR_FLAG_LSB 28
`define BMR_IRQ_OFF_BIT 7
`define BMR_FAST_OFF_BIT 6
`define BMR_STATE_BIT 5
`define BMR_MODE_MSB 4

// ---------------------------------------------------------------
// mode codes
// ---------------------------------------------------------------
`define BMR_MODE_USR 5'h10
`define BMR_MODE_FAST 5'h11
`define BMR_MODE_IRQ 5'h12
`define BMR_MODE_SVC 5'h13
`define BMR_MODE_ABT 5'h17
`define BMR_MODE_UND 5'h1b
`define BMR_MODE_SYS 5'h1f

// ---------------------------------------------------------------
// reset values, vectors, exception bit positions
// ---------------------------------------------------------------
`define BMR_STATUS_RST 32'h0000_00d3
`define BMR_PC_RST 32'h0000_0000
`define BMR_VEC_UND 32'h0000_0004
`define BMR_VEC_TRAP 32'h0000_0008
`define BMR_VEC_ABT 32'h0000_0010
`define BMR_VEC_IRQ 32'h0000_0018
`define BMR_VEC_FAST 32'h0000_001c
`define BMR_EXC_FAST 0
`define BMR_EXC_IRQ 1
`define BMR_EXC_ABT 2
`define BMR_EXC_UND 3
`define BMR_EXC_TRAP 4
`define BMR_STEP_WIDE 32'h0000_0004
`define BMR_STEP_COMPACT 32'h0000_0002
`define BMR_NO_SAVED 3'h5

`endif

// [bmr_pkg.sv]
// types shared by the banked mode register file
package bmr_pkg;
  `include "bmr_defs.svh"

  typedef enum logic [4:0]
  {
    BMR_USR = `BMR_MODE_USR,
    BMR_FAST = `BMR_MODE_FAST,
    BMR_IRQ = `BMR_MODE_IRQ,
    BMR_SVC = `BMR_MODE_SVC,
    BMR_ABT = `BMR_MODE_ABT,
    BMR_UND = `BMR_MODE_UND,
    BMR_SYS = `BMR_MODE_SYS
  } bmr_mode_type;

  // gray codes along the fill path
  typedef enum logic [1:0]
  {
    BMR_PIPE_EMPTY = 2'b00,
    BMR_PIPE_HALF = 2'b01,
    BMR_PIPE_FULL = 2'b11
  } bmr_pipe_type;

  typedef enum logic [1:0]
  {
    BMR_SZ_BYTE = 2'b00,
    BMR_SZ_HALF = 2'b01,
    BMR_SZ_WORD = 2'b10
  } bmr_size_type;
endpackage : bmr_pkg

// [bmr_cond_eval.sv]
// condition field evaluation against the alu flags
module bmr_cond_eval
(
  input wire logic [3:0] cond,
  input wire logic [3:0] nzcv,
  output logic pass
);
  logic n, z, c, v;
  assign n = nzcv[3];
  assign z = nzcv[2];
  assign c = nzcv[1];
  assign v = nzcv[0];

  always_comb
  begin
    unique case (cond)
      4'h0: pass = z;
      4'h1: pass = ~z;
      4'h2: pass = c;
      4'h3: pass = ~c;
      4'h4: pass = n;
      4'h5: pass = ~n;
      4'h6: pass = v;
      4'h7: pass = ~v;
      4'h8: pass = c & ~z;
      4'h9: pass = ~c | z;
      4'ha: pass = n == v;
      4'hb: pass = n != v;
      4'hc: pass = ~z & (n == v);
      4'hd: pass = z | (n != v);
      4'he: pass = 1'b1;
      4'hf: pass = 1'b0; // reserved code never executes
    endcase
  end
endmodule : bmr_cond_eval

// [bmr_regfile_asserts.sv]
// concurrent checks on the ports of the banked mode register file
module bmr_regfile_asserts
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  input wire logic exc_allow,
  input wire logic ret_dp_req,
  input wire logic ret_lmr_req,
  input wire logic step,
  input wire logic wr_en,
  input wire logic flag_we,
  input wire logic [3:0] flag_nzcv,
  input wire logic [3:0] rd_a_idx,
  input wire logic dacc_valid,
  input wire logic [31:0] dacc_addr,
  input wire bmr_pkg::bmr_size_type dacc_size,
  input wire logic [31:0] rd_a_data,
  input wire logic [31:0] program_counter,
  input wire logic [31:0] current_status_word,
  input wire logic [31:0] exe_word,
  input wire logic exe_fire,
  input wire logic dacc_misaligned,
  input wire logic privileged
);
  import bmr_pkg::*;
  // ----
  // quiet core: no bus access, entry or return; core writes, calls, flag writes and steps can still move state
  // ----
  wire quiet = !psel && !exc_allow && !ret_dp_req && !ret_lmr_req;
  wire user_mode = current_status_word[4:0] == BMR_USR;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence step_only;
    step && !wr_en && quiet;
  endsequence
  sequence half_odd;
    dacc_valid && dacc_size == BMR_SZ_HALF && dacc_addr[0];
  endsequence
  priv_mode_a: assert property (privileged == !user_mode)
    else $error("privileged flag disagrees with mode field");
  slverr_phase_a: assert property (pslverr |-> psel && penable)
    else $error("bus error outside access phase");
  step_pc_a: assert property (step_only |=> program_counter ==
    $past(program_counter) + ($past(current_status_word[5]) ? 32'h2 : 32'h4))
    else $error("program counter step wrong");
  pc_read_a: assert property (rd_a_idx == 4'hf |=> rd_a_data == $past(program_counter))
    else $error("register 15 read is not the program counter");
  word_align_a: assert property (dacc_valid && dacc_size == BMR_SZ_WORD &&
    dacc_addr[1:0] != 2'b00 |=> dacc_misaligned)
    else $error("unaligned word not flagged");
  half_align_a: assert property (half_odd |=> dacc_misaligned)
    else $error("odd halfword not flagged");
  byte_align_a: assert property (dacc_valid && dacc_size == BMR_SZ_BYTE |=> !dacc_misaligned)
    else $error("byte access flagged");
  user_ret_a: assert property (ret_dp_req && user_mode && !psel && !exc_allow && !flag_we
    |=> $stable(current_status_word))
    else $error("return in user mode changed status");
  flag_upd_a: assert property (flag_we && quiet |=>
    current_status_word[31:28] == $past(flag_nzcv))
    else $error("flags not updated");
  cond_never_a: assert property (exe_fire && !current_status_word[5] |->
    exe_word[31:28] != 4'hf)
    else $error("never condition executed");
endmodule : bmr_regfile_asserts

bind bmr_regfile bmr_regfile_asserts u_chk
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pslverr(pslverr),
  .exc_allow(exc_allow), .ret_dp_req(ret_dp_req), .ret_lmr_req(ret_lmr_req),
  .step(step), .wr_en(wr_en), .flag_we(flag_we), .flag_nzcv(flag_nzcv),
  .rd_a_idx(rd_a_idx), .dacc_valid(dacc_valid), .dacc_addr(dacc_addr),
  .dacc_size(dacc_size), .rd_a_data(rd_a_data), .program_counter(program_counter),
  .current_status_word(current_status_word), .exe_word(exe_word), .exe_fire(exe_fire),
  .dacc_misaligned(dacc_misaligned), .privileged(privileged)
);

// [tb_banked_mode_register_file.sv]
// self-checking bench for the banked mode register file
`include "bmr_defs.svh"
`define CHK(nm, e, g) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("unexpected %s: expected %h seen %h", nm, e, g); \
    end \
  end
module tb_banked_mode_register_file;
  timeunit 1ns;
  timeprecision 1ps;
  import bmr_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, wr_data, fetch_word, dacc_addr, p0;
  logic fast_pin, irq_pin, abort_req, undef_req, trap_req, exc_allow, ret_dp_req;
  logic ret_lmr_req, call_req, step, wr_en, flag_we, dacc_valid;
  logic [3:0] rd_a_idx, rd_b_idx, wr_idx, flag_nzcv;
  bmr_size_type dacc_size;
  logic [31:0] rd_a_data, rd_b_data, program_counter, current_status_word, exe_word;
  logic exe_fire, dacc_misaligned, privileged;
  logic [32:0] rq;
  int n_errors, tests_run;
  bmr_size_type ma_sz [4] = '{BMR_SZ_BYTE, BMR_SZ_HALF, BMR_SZ_WORD, BMR_SZ_WORD};
  logic [31:0] ma_ad [4] = '{32'h3, 32'h1, 32'h2, 32'h4};
  logic [3:0] cd [4] = '{4'he, 4'hf, 4'h0, 4'h1};
  logic [4:0] md [7] = '{5'h11, 5'h12, 5'h13, 5'h17, 5'h1b, 5'h1f, 5'h10};

  bmr_regfile DUT
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fast_pin(fast_pin), .irq_pin(irq_pin), .abort_req(abort_req), .undef_req(undef_req),
    .trap_req(trap_req), .exc_allow(exc_allow), .ret_dp_req(ret_dp_req),
    .ret_lmr_req(ret_lmr_req), .call_req(call_req), .step(step), .fetch_word(fetch_word),
    .rd_a_idx(rd_a_idx), .rd_b_idx(rd_b_idx), .wr_en(wr_en), .wr_idx(wr_idx),
    .wr_data(wr_data), .flag_we(flag_we), .flag_nzcv(flag_nzcv), .dacc_valid(dacc_valid),
    .dacc_addr(dacc_addr), .dacc_size(dacc_size), .rd_a_data(rd_a_data),
    .rd_b_data(rd_b_data), .program_counter(program_counter),
    .current_status_word(current_status_word), .exe_word(exe_word), .exe_fire(exe_fire),
    .dacc_misaligned(dacc_misaligned), .privileged(privileged)
  );

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----
  // bus and helper tasks
  // ----
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : cyc

  // pready is sampled at the rising edge, before the flops move
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 40);
    rq = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 40)
    begin
      n_errors++;
      results();
    end
    @(posedge pclk);
  endtask : apb

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(nm, {1'b0, x}, rq)
  endtask : rc

  task automatic gw(input logic [3:0] i, input logic [31:0] d);
    apb(1'b1, `BMR_OFF_REG_SEL, {28'h0, i});
    apb(1'b1, `BMR_OFF_REG_DATA, d);
  endtask : gw

  task automatic gr(input string nm, input logic [3:0] i, input logic [31:0] x);
    apb(1'b1, `BMR_OFF_REG_SEL, {28'h0, i});
    rc(nm, `BMR_OFF_REG_DATA, x);
  endtask : gr

  // raise exc_allow for one cycle to open one boundary, then wait two cycles
  task automatic boundary;
    exc_allow <= 1'b1;
    cyc(1);
    exc_allow <= 1'b0;
    cyc(2);
  endtask : boundary

  // ----
  // main sequence
  // ----
  initial
  begin
    {presetn, psel, penable, pwrite, fast_pin, irq_pin, abort_req, undef_req} = '0;
    {trap_req, exc_allow, ret_dp_req, ret_lmr_req, call_req, step, wr_en} = '0;
    {flag_we, dacc_valid, paddr, pwdata, wr_data, fetch_word, dacc_addr} = '0;
    {rd_a_idx, rd_b_idx, wr_idx, flag_nzcv} = '0;
    dacc_size = BMR_SZ_BYTE;
    cyc(5);
    presetn <= 1'b1;
    cyc(1);
    rc("status", `BMR_OFF_STATUS, `BMR_STATUS_RST);
    apb(1'b0, 8'h18, 32'h0);
    `CHK("unmapped", 33'h1_0000_0000, rq)
    $display("test reset done");
    for (int r = 0; r < 15; r++)
      gw(r[3:0], 32'h100 + r);
    apb(1'b1, `BMR_OFF_STATUS, 32'hd1);
    for (int r = 0; r < 15; r++)
      gr("fast reg", r[3:0], r < 8 ? 32'h100 + r : 32'h0);
    gw(4'h8, 32'haa);
    apb(1'b1, `BMR_OFF_STATUS, 32'hdf);
    for (int r = 0; r < 15; r++)
      gr("sys reg", r[3:0], r > 12 ? 32'h0 : 32'h100 + r);
    rc("sys saved", `BMR_OFF_SAVED, 32'h0);
    apb(1'b1, `BMR_OFF_STATUS, 32'hd3);
    gr("svc sp", 4'hd, 32'h10d);
    $display("test banking done");
    apb(1'b1, `BMR_OFF_STATUS, 32'h3f);
    @(negedge pclk);
    p0 = program_counter;
    @(posedge pclk);
    step <= 1'b1;
    cyc(1);
    step <= 1'b0;
    @(negedge pclk);
    `CHK("compact step", p0 + 32'h2, program_counter)
    @(posedge pclk);
    apb(1'b1, `BMR_OFF_STATUS, 32'h1f);
    gw(4'hf, 32'h100);
    apb(1'b1, `BMR_OFF_STATUS, 32'h10);
    apb(1'b1, `BMR_OFF_STATUS, 32'hf000_00df);
    rc("user status", `BMR_OFF_STATUS, 32'hf000_0010);
    $display("test state done");
    abort_req <= 1'b1;
    trap_req <= 1'b1;
    cyc(1);
    abort_req <= 1'b0;
    trap_req <= 1'b0;
    boundary();
    rc("abt status", `BMR_OFF_STATUS, 32'hf000_0097);
    rc("abt saved", `BMR_OFF_SAVED, 32'hf000_0010);
    gr("abt link", 4'he, 32'hfc);
    gr("abt vector", 4'hf, `BMR_VEC_ABT);
    rc("pending", `BMR_OFF_EXC_PEND, 32'h10);
    ret_dp_req <= 1'b1;
    cyc(1);
    ret_dp_req <= 1'b0;
    cyc(1);
    rc("ret status", `BMR_OFF_STATUS, 32'hf000_0010);
    gr("ret pc", 4'hf, 32'hfc);
    boundary();
    rc("trap status", `BMR_OFF_STATUS, 32'hf000_0093);
    gr("trap link", 4'he, 32'hf8);
    ret_lmr_req <= 1'b1;
    cyc(1);
    ret_lmr_req <= 1'b0;
    cyc(1);
    ret_dp_req <= 1'b1;
    cyc(1);
    ret_dp_req <= 1'b0;
    cyc(1);
    rc("user ret", `BMR_OFF_STATUS, 32'hf000_0010);
    $display("test exceptions done");
    fast_pin <= 1'b1;
    irq_pin <= 1'b1;
    cyc(3);
    boundary();
    fast_pin <= 1'b0;
    rc("fast status", `BMR_OFF_STATUS, 32'hf000_00d1);
    gr("fast vector", 4'hf, `BMR_VEC_FAST);
    boundary();
    rc("irq masked", `BMR_OFF_STATUS, 32'hf000_00d1);
    ret_dp_req <= 1'b1;
    cyc(1);
    ret_dp_req <= 1'b0;
    boundary();
    irq_pin <= 1'b0;
    rc("irq status", `BMR_OFF_STATUS, 32'hf000_0092);
    $display("test interrupts done");
    wr_en <= 1'b1;
    wr_idx <= 4'h3;
    wr_data <= 32'h5a5a_0003;
    flag_we <= 1'b1;
    flag_nzcv <= 4'h6;
    cyc(1);
    wr_en <= 1'b0;
    flag_we <= 1'b0;
    rd_a_idx <= 4'hf;
    rd_b_idx <= 4'h3;
    cyc(2);
    @(negedge pclk);
    `CHK("rd a", `BMR_VEC_IRQ, rd_a_data)
    `CHK("rd b", 32'h5a5a_0003, rd_b_data)
    `CHK("flags", 4'h6, current_status_word[31:28])
    @(posedge pclk);
    call_req <= 1'b1;
    cyc(1);
    call_req <= 1'b0;
    gr("call link", 4'he, `BMR_VEC_IRQ - 32'h4);
    for (int k = 0; k < 4; k++)
    begin
      fetch_word <= {cd[k], 28'h0};
      step <= 1'b1;
      cyc(3);
      step <= 1'b0;
      @(negedge pclk);
      `CHK("fire", 1'(k % 2 == 0), exe_fire)
      @(posedge pclk);
    end
    for (int k = 0; k < 4; k++)
    begin
      dacc_valid <= 1'b1;
      dacc_size <= ma_sz[k];
      dacc_addr <= ma_ad[k];
      cyc(1);
      dacc_valid <= 1'b0;
      @(negedge pclk);
      `CHK("misaligned", 1'(k == 1 || k == 2), dacc_misaligned)
      @(posedge pclk);
    end
    rc("info", `BMR_OFF_INFO, 32'hc0);
    apb(1'b1, `BMR_OFF_EXC_PEND, 32'h8);
    boundary();
    rc("und status", `BMR_OFF_STATUS, 32'h6000_009b);
    $display("test core ports done");
    for (int k = 0; k < 7; k++)
    begin
      apb(1'b1, `BMR_OFF_STATUS, {24'h0, 3'b110, md[k]});
      rc("mode", `BMR_OFF_STATUS, {24'h0, 3'b110, md[k]});
    end
    $display("test modes done");
    results();
  end
endmodule : tb_banked_mode_register_file
